//--- design/asr_pkg.sv
package asr_pkg;
  // apb register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;     // mode, test flag
  localparam logic [7:0] OFF_STATUS = 8'h04;   // scan state, timeouts
  localparam logic [7:0] OFF_TABLE = 8'h08;    // table index / data window
  localparam logic [7:0] OFF_TDATA = 8'h0c;    // table byte at index
  localparam logic [7:0] OFF_RESULT = 8'h10;   // filtered output at index
  localparam logic [7:0] OFF_SPEED = 8'h14;    // speed input/setpoint at index
  localparam logic [7:0] OFF_RELAY = 8'h18;    // relay status/output bytes
  localparam logic [7:0] OFF_DAC = 8'h1c;      // speed magnitude at index
  // field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_TEST_BIT = 4;
  localparam int CTRL_INIT_BIT = 5;
  localparam int ENTRY_LAST_BIT = 7;
  localparam int ENTRY_GAIN_LSB = 5;
  // reset values and counts
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int TIMEOUT_NS = 40000;
  localparam int CLK_NS = 4;
  localparam int TIMEOUT_CYC = TIMEOUT_NS / CLK_NS;
  localparam int SEL_BITS_ON = 3'b101;         // bit2 high, bit1 low, bit0 control
  typedef enum logic [3:0] {
    ASR_IDLE, ASR_DIR, ASR_FETCH, ASR_RDWAIT, ASR_MUX, ASR_FILT,
    ASR_RDY, ASR_CONV, ASR_PRE_RDY, ASR_PRE_CONV, ASR_RELAY
  } asr_state_t;
endpackage

//--- design/asr_scan_relay.sv
// Chosen here: the APB interface to the registers and the register offsets.
module asr_scan_relay #(
  parameter int CHANS = 32,
  parameter int DW = 16,
  parameter int TIMEOUT = asr_pkg::TIMEOUT_CYC
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic adc_ready_i,
  input wire logic adc_avail_i,
  input wire logic [DW-1:0] adc_data_i,
  output logic [4:0] mux_chan_o,
  output logic [1:0] mux_gain_o,
  output logic adc_start_o,
  input wire logic [7:0] dir_status_i,
  output logic [7:0] dir_out_o,
  output logic [2:0] sel_out_o,
  output logic sel_oe_o,
  output logic busy_o
);
  localparam int AW = $clog2(2 * CHANS);
  localparam int CW = $clog2(CHANS);
  // parameter table, results, speeds
  logic [7:0] table_reg [2*CHANS];        // two bytes per logical channel
  logic [DW-1:0] result_reg [CHANS];       // filtered outputs, also filter state
  logic signed [DW-1:0] speed_reg [4];     // speed outputs (signed)
  logic signed [DW-1:0] setp_reg [4];      // speed setpoints
  logic signed [DW-1:0] spin_reg [4];      // speed input values
  logic [DW-1:0] dac_reg [4];              // magnitudes to the converter
  logic [7:0] ctrl_reg;
  logic [7:0] idx_reg;
  logic [7:0] dstat_reg;                   // direction status as read
  logic [7:0] dir_reg;                     // last relay byte written
  logic sel_written_reg;
  logic [1:0] tmo_reg;                     // sticky ready/data timeout flags
  asr_pkg::asr_state_t st_reg;
  logic [CW-1:0] ch_reg;                   // logical channel in progress
  logic [DW-1:0] sample_reg;
  logic [31:0] wait_reg;
  logic [2:0] tick_sync_reg;               // pin synchroniser
  logic [2:0] rdy_sync_reg;
  logic [2:0] av_sync_reg;
  logic tick_seen_reg;
  logic av_low_reg;                        // data flag seen low since the last start
  logic init_run_reg;                      // priming run started by the init request

  // synchronised pin levels: second and third stage must agree
  wire tick_s = tick_sync_reg[1] & tick_sync_reg[2];
  wire tick_fall = ~tick_sync_reg[1] & ~tick_sync_reg[2];
  wire rdy_s = rdy_sync_reg[1] & rdy_sync_reg[2];
  wire av_s = av_sync_reg[1] & av_sync_reg[2];
  // the flag of the previous conversion still stands in the synchroniser for a few
  // cycles after a start, so a result only counts once the flag has been seen low
  wire av_new = av_s & av_low_reg;
  wire [2:0] mode = ctrl_reg[2:0];
  wire test_on = ctrl_reg[asr_pkg::CTRL_TEST_BIT];
  wire in_charge = (mode >= 3'd1) && (mode <= 3'd4);

  // apb decode; the slave always answers in the access cycle
  wire wr_en = psel_i & penable_i & pwrite_i;
  wire [AW-1:0] tidx = idx_reg[AW-1:0];
  wire [CW-1:0] ridx = idx_reg[CW-1:0];
  wire [1:0] midx = idx_reg[1:0];
  wire mapped = (paddr_i[1:0] == 2'b00) && (paddr_i <= asr_pkg::OFF_DAC);
  wire scanning = (st_reg != asr_pkg::ASR_IDLE);

  // entry fields of the current channel
  wire [AW-1:0] ent_a = {ch_reg, 1'b0};
  wire [7:0] ent0 = table_reg[ent_a];
  wire [7:0] ent1 = table_reg[ent_a + AW'(1)];
  wire ent_last = ent0[asr_pkg::ENTRY_LAST_BIT];
  wire [7:0] nxt0 = table_reg[ent_a + AW'(2)];
  wire nxt_last = nxt0[asr_pkg::ENTRY_LAST_BIT] || (ch_reg == CW'(CHANS - 1));

  // first-order smoother: y + (x - y) >> n equals a*x + b*y
  function automatic logic [DW-1:0] smooth(input logic [DW-1:0] x, input logic [DW-1:0] y,
                                           input logic [7:0] code);
    logic signed [DW:0] d;
    d = $signed({1'b0, x}) - $signed({1'b0, y});
    if (code == 8'h00)
      smooth = x;
    else
      smooth = DW'($signed({1'b0, y}) + (d >>> code[2:0]));
  endfunction

  // absolute value of a speed output
  function automatic logic [DW-1:0] magn(input logic signed [DW-1:0] v);
    magn = v[DW-1] ? DW'(-v) : DW'(v);
  endfunction

  // command code from setpoint sign
  function automatic logic [1:0] dir_code(input logic signed [DW-1:0] v);
    dir_code = (v == '0) ? 2'b00 : (v[DW-1] ? 2'b01 : 2'b10);
  endfunction

  // relay byte: commanded bits or-ed with status, zero setpoint clears
  logic [7:0] cmd_byte;
  logic [7:0] relay_byte;
  always_comb
  begin
    cmd_byte = 8'h00;
    relay_byte = 8'h00;
    for (int m = 0; m < 4; m++)
      cmd_byte[2*m +: 2] = dir_code(setp_reg[m]);
    relay_byte = cmd_byte | dstat_reg;
    for (int m = 0; m < 4; m++)
      if (setp_reg[m] == '0)
        relay_byte[2*m +: 2] = 2'b00;
  end

  // read mux
  always_comb
  begin
    prdata_o = 32'h0000_0000;
    unique case (paddr_i)
      asr_pkg::OFF_CTRL: prdata_o = {24'h000000, ctrl_reg};
      asr_pkg::OFF_STATUS: prdata_o = {24'h000000, 1'b0, sel_written_reg, tmo_reg, st_reg};
      asr_pkg::OFF_TABLE: prdata_o = {24'h000000, idx_reg};
      asr_pkg::OFF_TDATA: prdata_o = {24'h000000, table_reg[tidx]};
      asr_pkg::OFF_RESULT: prdata_o = 32'(result_reg[ridx]);
      asr_pkg::OFF_SPEED: prdata_o = {16'(spin_reg[midx]), 16'(setp_reg[midx])};
      asr_pkg::OFF_RELAY: prdata_o = {16'h0000, dir_reg, dstat_reg};
      asr_pkg::OFF_DAC: prdata_o = 32'(dac_reg[midx]);
      default: prdata_o = 32'h0000_0000;
    endcase
  end
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~mapped;

  // pin synchronisers
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tick_sync_reg <= 3'b000;
      rdy_sync_reg <= 3'b000;
      av_sync_reg <= 3'b000;
    end
    else
    begin
      tick_sync_reg <= {tick_sync_reg[1:0], tick_i};
      rdy_sync_reg <= {rdy_sync_reg[1:0], adc_ready_i};
      av_sync_reg <= {av_sync_reg[1:0], adc_avail_i};
    end
  end

  // software registers; results are read-only to the bus
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl_reg <= asr_pkg::CTRL_RESET[7:0];
      idx_reg <= 8'h00;
      for (int i = 0; i < 2 * CHANS; i++)
        table_reg[i] <= 8'h80;                   // empty table ends at once
      for (int m = 0; m < 4; m++)
        setp_reg[m] <= '0;
    end
    else if (wr_en)
    begin
      unique case (paddr_i)
        asr_pkg::OFF_CTRL: ctrl_reg <= pwdata_i[7:0];
        asr_pkg::OFF_TABLE: idx_reg <= pwdata_i[7:0];
        asr_pkg::OFF_TDATA: table_reg[tidx] <= pwdata_i[7:0];
        asr_pkg::OFF_SPEED: setp_reg[midx] <= pwdata_i[DW-1:0];
        default: ;                               // other offsets are read only
      endcase
    end
    else if (ctrl_reg[asr_pkg::CTRL_INIT_BIT] && !scanning)
      ctrl_reg[asr_pkg::CTRL_INIT_BIT] <= 1'b0;  // init request consumed by the sequencer
  end

  // scan and relay sequencer
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_reg <= asr_pkg::ASR_IDLE;
      ch_reg <= '0;
      sample_reg <= '0;
      wait_reg <= 32'h0000_0000;
      tmo_reg <= 2'b00;
      tick_seen_reg <= 1'b0;
      av_low_reg <= 1'b0;
      init_run_reg <= 1'b0;
      mux_chan_o <= 5'h00;
      mux_gain_o <= 2'b00;
      adc_start_o <= 1'b0;
      dstat_reg <= 8'h00;
      dir_reg <= 8'h00;
      sel_written_reg <= 1'b0;
      for (int i = 0; i < CHANS; i++)
        result_reg[i] <= '0;
      for (int m = 0; m < 4; m++)
      begin
        speed_reg[m] <= '0;
        spin_reg[m] <= '0;
        dac_reg[m] <= '0;
      end
    end
    else
    begin
      adc_start_o <= 1'b0;
      if (tick_fall)
        tick_seen_reg <= 1'b0;
      unique case (st_reg)
        asr_pkg::ASR_IDLE:
        begin
          // every run starts its wait count from zero, so the priming step selects the channel
          wait_reg <= 32'h0000_0000;
          if (ctrl_reg[asr_pkg::CTRL_INIT_BIT])
          begin
            ch_reg <= '0;
            init_run_reg <= 1'b1;                // relays stay untouched on this run
            st_reg <= asr_pkg::ASR_PRE_RDY;      // init primes first channel
          end
          else if (tick_s && !tick_seen_reg)
          begin
            tick_seen_reg <= 1'b1;
            ch_reg <= '0;
            st_reg <= test_on ? asr_pkg::ASR_IDLE : asr_pkg::ASR_FETCH;
          end
        end
        asr_pkg::ASR_FETCH:
        begin
          // a timed-out channel also lands here, with its count still high
          wait_reg <= 32'h0000_0000;
          if (ent_last)
            st_reg <= asr_pkg::ASR_PRE_RDY;      // end of table
          else
            st_reg <= asr_pkg::ASR_RDWAIT;
        end
        asr_pkg::ASR_RDWAIT:
        begin
          // first result was converted during the previous pass
          sample_reg <= adc_data_i;
          st_reg <= asr_pkg::ASR_MUX;
        end
        asr_pkg::ASR_MUX:
        begin
          // the next channel is selected now so that its settling runs during filtering
          if (!nxt_last)
          begin
            mux_chan_o <= nxt0[4:0];
            mux_gain_o <= nxt0[6:5];
          end
          st_reg <= asr_pkg::ASR_FILT;
        end
        asr_pkg::ASR_FILT:
        begin
          // settling of the mux overlaps this step
          result_reg[ch_reg] <= smooth(sample_reg, result_reg[ch_reg], ent1);
          wait_reg <= 32'h0000_0000;
          if (nxt_last)
            st_reg <= asr_pkg::ASR_PRE_RDY;
          else
          begin
            ch_reg <= ch_reg + CW'(1);
            st_reg <= asr_pkg::ASR_RDY;
          end
        end
        asr_pkg::ASR_RDY, asr_pkg::ASR_PRE_RDY:
        begin
          if (st_reg == asr_pkg::ASR_PRE_RDY && wait_reg == 32'h0000_0000)
          begin
            mux_chan_o <= table_reg[0][4:0];      // first table channel
            mux_gain_o <= table_reg[0][6:5];
          end
          wait_reg <= wait_reg + 32'h0000_0001;
          // a start only follows a ready seen through the synchroniser
          if (rdy_s)
          begin
            adc_start_o <= 1'b1;
            av_low_reg <= 1'b0;
            wait_reg <= 32'h0000_0000;
            st_reg <= (st_reg == asr_pkg::ASR_RDY) ? asr_pkg::ASR_CONV : asr_pkg::ASR_PRE_CONV;
          end
          else if (wait_reg >= 32'(TIMEOUT))
          begin
            tmo_reg[0] <= 1'b1;
            init_run_reg <= 1'b0;
            if (st_reg == asr_pkg::ASR_RDY)
              st_reg <= asr_pkg::ASR_FETCH;
            else
              st_reg <= init_run_reg ? asr_pkg::ASR_IDLE : asr_pkg::ASR_DIR;
          end
        end
        asr_pkg::ASR_CONV, asr_pkg::ASR_PRE_CONV:
        begin
          wait_reg <= wait_reg + 32'h0000_0001;
          if (!av_s)
            av_low_reg <= 1'b1;                   // old result has left the synchroniser
          if (av_new || wait_reg >= 32'(TIMEOUT))
          begin
            // a timed-out conversion still hands on whatever the data lines show
            if (!av_new)
              tmo_reg[1] <= 1'b1;
            if (st_reg == asr_pkg::ASR_CONV)
            begin
              sample_reg <= adc_data_i;
              st_reg <= asr_pkg::ASR_MUX;
            end
            else
            begin
              // only the priming run asked for by init leaves the relays alone
              init_run_reg <= 1'b0;
              st_reg <= init_run_reg ? asr_pkg::ASR_IDLE : asr_pkg::ASR_DIR;
            end
          end
        end
        asr_pkg::ASR_DIR:
        begin
          // read status; stopped motors report zero speed
          dstat_reg <= dir_status_i;
          for (int m = 0; m < 4; m++)
            spin_reg[m] <= (dir_status_i[2*m +: 2] == 2'b00) ? '0 : speed_reg[m];
          st_reg <= asr_pkg::ASR_RELAY;
        end
        asr_pkg::ASR_RELAY:
        begin
          dir_reg <= relay_byte;
          sel_written_reg <= 1'b1;
          for (int m = 0; m < 4; m++)
          begin
            speed_reg[m] <= (setp_reg[m] == '0) ? '0 : setp_reg[m];
            dac_reg[m] <= magn(setp_reg[m]);
          end
          st_reg <= asr_pkg::ASR_IDLE;
        end
        default: st_reg <= asr_pkg::ASR_IDLE;
      endcase
    end
  end

  // relay lines only driven once all selection bits have been written
  assign sel_oe_o = sel_written_reg;
  assign sel_out_o = sel_written_reg ? {2'b10, in_charge} : 3'b000;
  assign dir_out_o = in_charge ? dir_reg : 8'h00;
  assign busy_o = scanning;
endmodule

//--- bench/asr_scan_relay_props.sv
module asr_scan_relay_props (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic adc_ready_i,
  input wire logic adc_start_o,
  input wire logic [4:0] mux_chan_o,
  input wire logic [7:0] dir_out_o,
  input wire logic [2:0] sel_out_o,
  input wire logic sel_oe_o,
  input wire logic busy_o
);
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  // a start is followed by quiet cycles while the sample is awaited
  sequence s_gap;
    !adc_start_o [*3];
  endsequence
  property p_gap;
    adc_start_o |=> s_gap;
  endproperty
  a_gap: assert property (p_gap) else $error("starts too close");
  // ready must have been seen through the synchroniser
  property p_rdy;
    adc_start_o |-> $past(adc_ready_i, 3);
  endproperty
  a_rdy: assert property (p_rdy) else $error("start without ready");
  property p_run;
    adc_start_o || $changed(mux_chan_o) |-> busy_o || $past(busy_o);
  endproperty
  a_run: assert property (p_run) else $error("converter touched while idle");
  property p_pat;
    sel_oe_o |-> sel_out_o[2:1] == 2'b10;
  endproperty
  a_pat: assert property (p_pat) else $error("enable pattern wrong");
  property p_float;
    !sel_oe_o |-> sel_out_o == 3'b000;
  endproperty
  a_float: assert property (p_float) else $error("selection before write");
  property p_keep;
    sel_oe_o |=> sel_oe_o;
  endproperty
  a_keep: assert property (p_keep) else $error("selection drive dropped");
  property p_gate;
    !sel_out_o[0] |-> dir_out_o == 8'h00;
  endproperty
  a_gate: assert property (p_gate) else $error("relays driven in monitoring");
  // new relay bytes only come from a pass
  property p_upd;
    $changed(dir_out_o) && dir_out_o != 8'h00 && $past(sel_out_o[0]) |-> busy_o || $past(busy_o);
  endproperty
  a_upd: assert property (p_upd) else $error("relay byte changed outside pass");
endmodule

bind asr_scan_relay asr_scan_relay_props chk_u (.clock_i(clock_i), .rst_i(rst_i), .adc_ready_i(adc_ready_i),
  .adc_start_o(adc_start_o), .mux_chan_o(mux_chan_o), .dir_out_o(dir_out_o), .sel_out_o(sel_out_o),
  .sel_oe_o(sel_oe_o), .busy_o(busy_o));

//--- bench/asr_adc_model.sv
module asr_adc_model (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [4:0] chan_i,
  input wire logic [1:0] gain_i,
  input wire logic [7:0] dir_i,
  input wire logic slow_i,
  input wire logic dead_i,
  output logic ready_o,
  output logic avail_o,
  output logic [15:0] data_o,
  output logic [7:0] status_o
);
  logic [3:0] cnt_reg; // cycles left in a conversion
  logic [15:0] val_reg; // value tagged with channel and gain
  // data lines show the inverse when not valid, so stale data never matches
  assign data_o = avail_o ? val_reg : ~val_reg;
  // converter and relay read-back; a dead board never finishes
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ready_o <= 1'b1;
      avail_o <= 1'b0;
      cnt_reg <= 4'h0;
      val_reg <= 16'h0000;
      status_o <= 8'h00;
    end
    else
    begin
      for (int m = 0; m < 4; m++)
        status_o[2*m+:2] <= (^dir_i[2*m+:2]) ? dir_i[2*m+:2] : 2'b00;
      if (start_i)
      begin
        ready_o <= 1'b0;
        avail_o <= 1'b0;
        val_reg <= {3'b000, chan_i, 2'b00, gain_i, 4'h1};
        cnt_reg <= slow_i ? 4'h9 : 4'h2;
      end
      else if (cnt_reg == 4'h1 && !dead_i)
      begin
        avail_o <= 1'b1;
        ready_o <= 1'b1;
        cnt_reg <= 4'h0;
      end
      else if (cnt_reg > 4'h1)
        cnt_reg <= cnt_reg - 4'h1;
    end
  end
endmodule

//--- bench/analog_scan_and_motor_relay_io_test.sv
module analog_scan_and_motor_relay_io_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i, rst_i, tick, psel, pen, pwr, rdy, avl, start, slow, dead, oe, busy, prdy, perr, er;
  logic [7:0] addr, dout, dst;
  logic [31:0] wdat, prd, rd;
  logic [15:0] adat;
  logic [4:0] chan;
  logic [1:0] gain;
  logic [2:0] sel;
  int err_count = 0;
  int compares = 0;
  int cyc = 0;
  int nst = 0;
  int n0;
  initial
  begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  // short timeout keeps the dead-board case quick
  asr_scan_relay #(.TIMEOUT(20)) dut_u (.clock_i(clock_i), .rst_i(rst_i), .tick_i(tick), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(addr), .pwdata_i(wdat), .prdata_o(prd), .pready_o(prdy),
    .pslverr_o(perr), .adc_ready_i(rdy), .adc_avail_i(avl), .adc_data_i(adat), .mux_chan_o(chan),
    .mux_gain_o(gain), .adc_start_o(start), .dir_status_i(dst), .dir_out_o(dout), .sel_out_o(sel),
    .sel_oe_o(oe), .busy_o(busy));
  asr_adc_model far_u (.clock_i(clock_i), .rst_i(rst_i), .start_i(start), .chan_i(chan), .gain_i(gain),
    .dir_i(dout), .slow_i(slow), .dead_i(dead), .ready_o(rdy), .avail_o(avl), .data_o(adat), .status_o(dst));
  task conclude;
    if (err_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is seen
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel <= 1'b1;
    pwr <= w;
    addr <= a;
    wdat <= d;
    @(posedge clock_i);
    pen <= 1'b1;
    do
      @(posedge clock_i);
    while (prdy !== 1'b1);
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task wix(input logic [7:0] a, input logic [31:0] i, input logic [31:0] d);
    apb(1'b1, asr_pkg::OFF_TABLE, i);
    apb(1'b1, a, d);
  endtask
  task rix(input logic [7:0] a, input logic [31:0] i);
    apb(1'b1, asr_pkg::OFF_TABLE, i);
    apb(1'b0, a, 32'h0);
  endtask
  // one second tick, then wait for the pass to end
  task pass_run;
    int n;
    n = 0;
    tick <= 1'b1;
    repeat (10) @(posedge clock_i);
    tick <= 1'b0;
    while (busy !== 1'b0 && n < 3000)
    begin
      @(posedge clock_i);
      n++;
    end
    repeat (2) @(posedge clock_i);
  endtask
  task t_reset;
    chk(sel, 3'b000);
    chk(oe, 1'b0);
    apb(1'b0, asr_pkg::OFF_CTRL, 32'h0);
    chk(rd, asr_pkg::CTRL_RESET);
    apb(1'b0, 8'h40, 32'h0);
    chk(er, 1'b1);
  endtask
  // two channels, second filtered; terminator has junk low bits
  task t_scan;
    wix(asr_pkg::OFF_TDATA, 0, 8'h43);
    wix(asr_pkg::OFF_TDATA, 1, 8'h00);
    wix(asr_pkg::OFF_TDATA, 2, 8'h65);
    wix(asr_pkg::OFF_TDATA, 3, 8'h02);
    wix(asr_pkg::OFF_TDATA, 4, 8'hff);
    apb(1'b1, asr_pkg::OFF_CTRL, 32'h21);
    // let the priming run end before starts are counted
    repeat (40) @(posedge clock_i);
    chk(oe, 1'b0);
    n0 = nst;
    pass_run;
    chk(nst - n0, 2);
    chk(sel, 3'b101);
    chk(oe, 1'b1);
    chk({chan, gain}, {5'd3, 2'd2});
    rix(asr_pkg::OFF_RESULT, 0);
    chk(rd[15:0], 16'h0321);
    rix(asr_pkg::OFF_RESULT, 1);
    chk(rd[15:0], 16'h014c);
    pass_run;
    rix(asr_pkg::OFF_RESULT, 1);
    chk(rd[15:0], 16'h0245);
  endtask
  // slow converter; reversal of motor 0 forces a stop pass
  task t_relay;
    slow <= 1'b1;
    wix(asr_pkg::OFF_SPEED, 0, 32'h5);
    wix(asr_pkg::OFF_SPEED, 1, 32'hfffb);
    wix(asr_pkg::OFF_SPEED, 2, 32'h0);
    wix(asr_pkg::OFF_SPEED, 3, 32'h1);
    pass_run;
    chk(dout, 8'h86);
    rix(asr_pkg::OFF_DAC, 1);
    chk(rd[15:0], 16'h0005);
    rix(asr_pkg::OFF_SPEED, 2);
    chk(rd[31:16], 16'h0000);
    wix(asr_pkg::OFF_SPEED, 0, 32'hfffb);
    pass_run;
    chk(dout, 8'h87);
    rix(asr_pkg::OFF_SPEED, 0);
    chk(rd[31:16], 16'h0005);
    pass_run;
    chk(dout, 8'h85);
    rix(asr_pkg::OFF_SPEED, 0);
    chk(rd[31:16], 16'h0000);
    slow <= 1'b0;
  endtask
  task t_test;
    apb(1'b1, asr_pkg::OFF_CTRL, 32'h11);
    n0 = nst;
    pass_run;
    chk(nst, n0);
  endtask
  task t_dead;
    apb(1'b1, asr_pkg::OFF_CTRL, 32'h01);
    dead <= 1'b1;
    pass_run;
    apb(1'b0, asr_pkg::OFF_STATUS, 32'h0);
    chk(rd[5:4], 2'b11);
    dead <= 1'b0;
  endtask
  task t_mon;
    apb(1'b1, asr_pkg::OFF_CTRL, 32'h0);
    pass_run;
    chk(sel, 3'b100);
    chk(dout, 8'h00);
  endtask
  // cycle count, start count and hang guard
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (start)
      nst <= nst + 1;
    if (cyc == 40000)
    begin
      err_count++;
      conclude();
    end
  end
  initial
  begin
    {tick, psel, pen, pwr, slow, dead} = 6'h00;
    addr = 8'h00;
    wdat = 32'h0;
    rst_i = 1'b1;
    repeat (16) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    t_reset;
    t_scan;
    t_relay;
    t_test;
    t_dead;
    t_mon;
    conclude();
  end
endmodule
